// ===== logic/usb_fifo_host_params.svh
// Purpose: Constants for the parallel FIFO port host controller
// Assumes: Host clock at 100 MHz
// Notes: Times in ns, cycle counts derived from them
`ifndef USB_FIFO_HOST_PARAMS_SVH
`define USB_FIFO_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RD_PULSE_NS 30
`define RD_DATA_NS 14
`define WR_PULSE_NS 30
`define WR_SETUP_NS 5
`define WR_HOLD_NS 5
`define SYNC_DEPTH 2

`define RD_PULSE_CYC `CEIL_CYC(`RD_PULSE_NS)
`define RD_DATA_CYC (`CEIL_CYC(`RD_DATA_NS) + `SYNC_DEPTH)
`define RD_LOW_CYC ((`RD_PULSE_CYC > `RD_DATA_CYC) ? `RD_PULSE_CYC : `RD_DATA_CYC)
`define WR_LOW_CYC `CEIL_CYC(`WR_PULSE_NS)
`define WR_SETUP_CYC `CEIL_CYC(`WR_SETUP_NS)
`define WR_HOLD_CYC `CEIL_CYC(`WR_HOLD_NS)

`define CNT_W 3
`define FLAG_RX 0
`define FLAG_TX 1
`define FLAG_CFG 2
`define FLAG_RST 3'h3
`define BYTE_RST 8'h00
`define CNT_RST 3'h0
`define PIN_IDLE 1'b1
`define PIN_ACT 1'b0

`endif

// ===== logic/usb_fifo_host_pkg.sv
// Purpose: Types for the parallel FIFO port host controller
// Assumes: Nothing
// Notes: State codes are binary
package usb_fifo_host_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RD_OE = 2'b01,
    S_RD = 2'b10,
    S_WR = 2'b11
  } link_state_t;
  typedef enum logic [2:0] {
    A_IDLE = 3'b000,
    A_RD = 3'b001,
    A_RD_END = 3'b010,
    A_WR_SETUP = 3'b011,
    A_WR = 3'b100,
    A_WR_HOLD = 3'b101,
    A_WR_END = 3'b110
  } async_state_t;
endpackage

// ===== logic/byte_chan_if.sv
// Purpose: Byte channel with valid and ready
// Assumes: Both ends on one clock
// Notes: Byte taken when valid and ready both high
`timescale 1ns/1ps
interface byte_chan_if;
  import usb_fifo_host_pkg::*;
  logic valid;
  logic ready;
  byte_t data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// ===== logic/byte_handoff.sv
// Purpose: Moves one byte at a time between two clock domains
// Assumes: Source word held until acknowledged
// Notes: Toggle request and toggle acknowledge, two flip-flop synchronisers
`timescale 1ns/1ps
`include "usb_fifo_host_params.svh"
module byte_handoff
  import usb_fifo_host_pkg::*;
(
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  byte_chan_if.consumer in_ch,
  byte_chan_if.producer out_ch
);
  logic req_t_r;
  byte_t hold_r;
  logic [1:0] ack_sync_r;
  logic [1:0] req_sync_r;
  logic seen_r;
  logic ack_t_r;
  logic out_valid_r;
  byte_t out_data_r;
  wire busy = req_t_r != ack_sync_r[1];
  wire fresh = req_sync_r[1] != seen_r;

  assign in_ch.ready = !busy;
  assign out_ch.valid = out_valid_r;
  assign out_ch.data = out_data_r;

  always_ff @(posedge src_clk or negedge src_rst_b) begin
    if (!src_rst_b) begin
      req_t_r <= 1'b0;
      hold_r <= `BYTE_RST;
      ack_sync_r <= 2'b00;
    end else begin
      ack_sync_r <= {ack_sync_r[0], ack_t_r};
      if (in_ch.valid && !busy) begin
        req_t_r <= ~req_t_r;
        hold_r <= in_ch.data;
      end
    end
  end

  // Held word is stable while the request is in flight
  always_ff @(posedge dst_clk or negedge dst_rst_b) begin
    if (!dst_rst_b) begin
      req_sync_r <= 2'b00;
      seen_r <= 1'b0;
      ack_t_r <= 1'b0;
      out_valid_r <= 1'b0;
      out_data_r <= `BYTE_RST;
    end else begin
      req_sync_r <= {req_sync_r[0], req_t_r};
      if (fresh && !out_valid_r) begin
        out_valid_r <= 1'b1;
        out_data_r <= hold_r;
        seen_r <= req_sync_r[1];
      end else if (out_valid_r && out_ch.ready) begin
        out_valid_r <= 1'b0;
        ack_t_r <= ~ack_t_r;
      end
    end
  end
endmodule

// ===== logic/usb_fifo_host.sv
// Purpose: Host controller driving a byte-wide USB FIFO port
// Assumes: Mode request changes only while the port is idle
// Notes: Sync mode runs on the port clock, async mode on the host clock
// Functional notes
// - Sync mode performs a read or a write at a time, never both.
// - Sync mode bytes move on rising edges of the port clock.
// - Sync mode allowed only once async mode is set in stored configuration.
// - Lower output enable first, then read strobe; first byte follows enable.
// - Reads may burst or insert wait states by raising read strobe; code raises read strobe after every byte.
// - Receive-available high ends reads; later bus data ignored.
// - Start sync write only while transmit-space low, strobe with valid data.
// - Writes may burst one byte per clock while transmit-space low; code raises write strobe after every byte.
// - Byte accepted only where transmit-space and write strobe both low.
// - Async read strobe only after receive-available is active.
// - Async write strobe only after transmit-space is active.
`timescale 1ns/1ps
`include "usb_fifo_host_params.svh"
module usb_fifo_host
  import usb_fifo_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic sync_mode_req,
  input wire logic nv_async_cfg,
  input wire logic tx_valid,
  input wire byte_t tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output byte_t rx_data,
  input wire logic rx_ready,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  output logic fifo_rd_n,
  output logic fifo_wr_n,
  output logic fifo_oe_n,
  input wire byte_t fifo_data_in,
  output byte_t fifo_data_out,
  output logic fifo_data_oe
);
  function automatic logic cnt_hit(input logic [`CNT_W-1:0] c, input int lim);
    return c == `CNT_W'(lim - 1);
  endfunction

  byte_chan_if tx_src ();
  byte_chan_if tx_dst ();
  byte_chan_if rx_src ();
  byte_chan_if rx_dst ();

  // Host clock domain
  logic [2:0] flag_s1_r;
  logic [2:0] flag_s2_r;
  byte_t dat_s1_r;
  byte_t dat_s2_r;
  logic mode_r;
  logic rx_valid_r;
  byte_t rx_data_r;
  async_state_t a_st_r;
  async_state_t a_st_nxt;
  logic [`CNT_W-1:0] a_cnt_r;
  logic [`CNT_W-1:0] a_cnt_nxt;
  logic a_rd_n_r;
  logic a_wr_n_r;
  logic a_doe_r;
  byte_t a_dout_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_s1_r <= `FLAG_RST;
      flag_s2_r <= `FLAG_RST;
      dat_s1_r <= `BYTE_RST;
      dat_s2_r <= `BYTE_RST;
    end else begin
      flag_s1_r <= {nv_async_cfg, tx_space_available_n, rx_data_available_n};
      flag_s2_r <= flag_s1_r;
      dat_s1_r <= fifo_data_in;
      dat_s2_r <= dat_s1_r;
    end
  end

  wire rxf_s = flag_s2_r[`FLAG_RX];
  wire txe_s = flag_s2_r[`FLAG_TX];
  wire cfg_s = flag_s2_r[`FLAG_CFG];
  wire a_idle = a_st_r == A_IDLE;
  wire a_start_rd = a_idle && !mode_r && !rxf_s && !rx_valid_r;
  wire a_tx_take = a_idle && !mode_r && !a_start_rd && !txe_s && tx_valid;
  wire a_capture = a_st_r == A_RD && cnt_hit(a_cnt_r, `RD_LOW_CYC);
  wire mode_nxt = a_idle ? (sync_mode_req && cfg_s) : mode_r;

  always_comb begin
    a_st_nxt = a_st_r;
    a_cnt_nxt = a_cnt_r + `CNT_W'(1);
    case (a_st_r)
      A_IDLE: begin
        a_cnt_nxt = `CNT_RST;
        if (a_start_rd) begin
          a_st_nxt = A_RD;
        end else if (a_tx_take) begin
          a_st_nxt = A_WR_SETUP;
        end
      end
      A_RD: begin
        if (a_capture) begin
          a_st_nxt = A_RD_END;
        end
      end
      A_RD_END: begin
        if (rxf_s) begin
          a_st_nxt = A_IDLE;
        end
      end
      A_WR_SETUP: begin
        if (cnt_hit(a_cnt_r, `WR_SETUP_CYC)) begin
          a_st_nxt = A_WR;
          a_cnt_nxt = `CNT_RST;
        end
      end
      A_WR: begin
        if (cnt_hit(a_cnt_r, `WR_LOW_CYC)) begin
          a_st_nxt = A_WR_HOLD;
          a_cnt_nxt = `CNT_RST;
        end
      end
      A_WR_HOLD: begin
        if (cnt_hit(a_cnt_r, `WR_HOLD_CYC)) begin
          a_st_nxt = A_WR_END;
        end
      end
      A_WR_END: begin
        if (txe_s) begin
          a_st_nxt = A_IDLE;
        end
      end
      default: begin
        a_st_nxt = A_IDLE;
      end
    endcase
  end

  wire a_rd_n_nxt = a_st_nxt != A_RD;
  wire a_wr_n_nxt = a_st_nxt != A_WR;
  wire a_doe_nxt = a_st_nxt == A_WR_SETUP || a_st_nxt == A_WR || a_st_nxt == A_WR_HOLD;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      a_st_r <= A_IDLE;
      a_cnt_r <= `CNT_RST;
      a_rd_n_r <= `PIN_IDLE;
      a_wr_n_r <= `PIN_IDLE;
      a_doe_r <= 1'b0;
      a_dout_r <= `BYTE_RST;
      mode_r <= 1'b0;
    end else begin
      a_st_r <= a_st_nxt;
      a_cnt_r <= a_cnt_nxt;
      a_rd_n_r <= a_rd_n_nxt;
      a_wr_n_r <= a_wr_n_nxt;
      a_doe_r <= a_doe_nxt;
      mode_r <= mode_nxt;
      if (a_tx_take) begin
        a_dout_r <= tx_data;
      end
    end
  end

  // Received byte stage toward the user
  assign rx_dst.ready = !rx_valid_r && !a_capture;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid_r <= 1'b0;
      rx_data_r <= `BYTE_RST;
    end else if (a_capture) begin
      rx_valid_r <= 1'b1;
      rx_data_r <= dat_s2_r;
    end else if (rx_dst.valid && rx_dst.ready) begin
      rx_valid_r <= 1'b1;
      rx_data_r <= rx_dst.data;
    end else if (rx_ready) begin
      rx_valid_r <= 1'b0;
    end
  end

  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign tx_src.valid = tx_valid && mode_r;
  assign tx_src.data = tx_data;
  assign tx_ready = mode_r ? tx_src.ready : a_tx_take;

  // Port clock domain, driven by the device in sync mode
  logic [1:0] link_rst_r;
  logic [1:0] link_mode_r;
  link_state_t s_st_r;
  link_state_t s_st_nxt;
  logic s_rd_n_r;
  logic s_rd_n_nxt;
  logic s_wr_n_r;
  logic s_wr_n_nxt;
  logic s_oe_n_r;
  logic s_oe_n_nxt;
  logic s_doe_r;
  logic s_doe_nxt;
  byte_t s_dout_r;
  wire link_rst_b = link_rst_r[1];
  wire link_mode = link_mode_r[1];

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_rst_r <= 2'b00;
    end else begin
      link_rst_r <= {link_rst_r[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      link_mode_r <= 2'b00;
    end else begin
      link_mode_r <= {link_mode_r[0], mode_r};
    end
  end

  wire s_idle = s_st_r == S_IDLE;
  wire rx_push = s_st_r == S_RD && !s_rd_n_r && !rx_data_available_n;
  wire tx_pop = s_st_r == S_WR && !s_wr_n_r && !tx_space_available_n;
  wire s_start_rd = s_idle && link_mode && !rx_data_available_n && rx_src.ready;
  wire s_start_wr = s_idle && link_mode && !s_start_rd && tx_dst.valid
    && !tx_space_available_n;

  assign rx_src.valid = rx_push;
  assign rx_src.data = fifo_data_in;
  assign tx_dst.ready = tx_pop;

  always_comb begin
    s_st_nxt = s_st_r;
    s_rd_n_nxt = `PIN_IDLE;
    s_wr_n_nxt = `PIN_IDLE;
    s_oe_n_nxt = s_oe_n_r;
    s_doe_nxt = 1'b0;
    case (s_st_r)
      S_IDLE: begin
        if (s_start_rd) begin
          s_st_nxt = S_RD_OE;
          s_oe_n_nxt = `PIN_ACT;
        end else if (s_start_wr) begin
          s_st_nxt = S_WR;
          s_wr_n_nxt = `PIN_ACT;
          s_doe_nxt = 1'b1;
        end
      end
      S_RD_OE: begin
        s_st_nxt = S_RD;
        s_rd_n_nxt = !(rx_src.ready && !rx_data_available_n);
      end
      S_RD: begin
        if (rx_data_available_n && !rx_push) begin
          s_st_nxt = S_IDLE;
          s_oe_n_nxt = `PIN_IDLE;
        end else begin
          s_rd_n_nxt = !(rx_src.ready && !rx_push && !rx_data_available_n);
        end
      end
      S_WR: begin
        if (tx_pop) begin
          s_st_nxt = S_IDLE;
        end else begin
          s_wr_n_nxt = `PIN_ACT;
          s_doe_nxt = 1'b1;
        end
      end
      default: begin
        s_st_nxt = S_IDLE;
        s_oe_n_nxt = `PIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      s_st_r <= S_IDLE;
      s_rd_n_r <= `PIN_IDLE;
      s_wr_n_r <= `PIN_IDLE;
      s_oe_n_r <= `PIN_IDLE;
      s_doe_r <= 1'b0;
      s_dout_r <= `BYTE_RST;
    end else begin
      s_st_r <= s_st_nxt;
      s_rd_n_r <= s_rd_n_nxt;
      s_wr_n_r <= s_wr_n_nxt;
      s_oe_n_r <= s_oe_n_nxt;
      s_doe_r <= s_doe_nxt;
      if (s_start_wr) begin
        s_dout_r <= tx_dst.data;
      end
    end
  end

  byte_handoff u_tx_handoff (
    .src_clk(clock),
    .src_rst_b(rst_b),
    .dst_clk(link_clk),
    .dst_rst_b(link_rst_b),
    .in_ch(tx_src),
    .out_ch(tx_dst)
  );

  byte_handoff u_rx_handoff (
    .src_clk(link_clk),
    .src_rst_b(link_rst_b),
    .dst_clk(clock),
    .dst_rst_b(rst_b),
    .in_ch(rx_src),
    .out_ch(rx_dst)
  );

  // Pin selection by mode; async mode keeps output enable high
  assign fifo_rd_n = mode_r ? s_rd_n_r : a_rd_n_r;
  assign fifo_wr_n = mode_r ? s_wr_n_r : a_wr_n_r;
  assign fifo_oe_n = mode_r ? s_oe_n_r : `PIN_IDLE;
  assign fifo_data_out = mode_r ? s_dout_r : a_dout_r;
  assign fifo_data_oe = mode_r ? s_doe_r : a_doe_r;

  sequence rd_low_run;
    !a_rd_n_r [*4];
  endsequence
  sequence wr_low_run;
    !a_wr_n_r [*3];
  endsequence
  sequence wr_hold_tail;
    a_wr_n_r && a_doe_r;
  endsequence

  chk_sync_no_overlap: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    !(!s_rd_n_r && !s_wr_n_r)) else $error("read and write strobes both low");
  chk_oe_before_rd: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    $fell(s_rd_n_r) |-> !s_oe_n_r && !$past(s_oe_n_r)) else $error("read before enable");
  chk_rd_wait_state: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    rx_push |=> s_rd_n_r) else $error("read strobe not raised after byte");
  chk_rd_end_flag: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    (s_st_r == S_RD && rx_data_available_n && !rx_push) |=> s_idle && s_oe_n_r)
    else $error("read not ended on empty flag");
  chk_wr_needs_space: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    $fell(s_wr_n_r) |-> !$past(tx_space_available_n) && s_doe_r)
    else $error("write started without space");
  chk_wr_held_untaken: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    (!s_wr_n_r && tx_space_available_n) |=> !s_wr_n_r && $stable(s_dout_r))
    else $error("write dropped before acceptance");
  chk_bus_no_clash: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    s_doe_r |-> s_oe_n_r) else $error("bus driven during read enable");
  chk_sync_cfg_gate: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(mode_r) |-> $past(cfg_s) && $past(sync_mode_req)) else $error("sync without config");
  chk_async_rd_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(a_rd_n_r) |-> rd_low_run ##1 a_rd_n_r) else $error("async read pulse width");
  chk_async_rd_flag: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(a_rd_n_r) |-> !$past(rxf_s)) else $error("async read without data flag");
  chk_async_wr_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(a_wr_n_r) |-> $past(a_doe_r) ##0 wr_low_run ##1 wr_hold_tail)
    else $error("async write timing");
  chk_async_no_oe: assert property (@(posedge clock) disable iff (!rst_b)
    !mode_r |-> fifo_oe_n) else $error("output enable used in async mode");
endmodule

// ===== tb/fifo_dev_model.sv
// Purpose: Behavioural byte FIFO device facing the host controller
// Assumes: sync_on set by the bench only while the port is idle
// Notes: Counts protocol slips of the host in viol
`timescale 1ns/1ps
module fifo_dev_model
  import usb_fifo_host_pkg::*;
#(
  parameter int HALF_NS = 15
)
(
  input wire logic sync_on,
  input wire logic fifo_rd_n,
  input wire logic fifo_wr_n,
  input wire logic fifo_oe_n,
  input wire byte_t fifo_data_out,
  input wire logic fifo_data_oe,
  output logic link_clk,
  output logic rx_data_available_n,
  output logic tx_space_available_n,
  output byte_t fifo_data_in
);
  byte_t rxq[$];
  byte_t txq[$];
  logic tx_stall = 1'b0;
  logic rec_rd = 1'b0;
  logic rec_wr = 1'b0;
  int viol = 0;

  initial begin
    link_clk = 1'b0;
    rx_data_available_n = 1'b1;
    tx_space_available_n = 1'b1;
    fifo_data_in = 8'h5A;
    #7;
    forever begin
      #HALF_NS;
      // Clock only in sync mode, still otherwise
      if (sync_on) link_clk = ~link_clk;
    end
  end

  always @(posedge link_clk) begin
    if (!fifo_rd_n && !fifo_wr_n) viol++;
    if (!fifo_rd_n && fifo_oe_n) viol++;
    if (!fifo_oe_n && fifo_data_oe) viol++;
    if (!fifo_rd_n && !rx_data_available_n && rxq.size() > 0) void'(rxq.pop_front());
    if (!fifo_wr_n && !tx_space_available_n) txq.push_back(fifo_data_out);
    #2;
    rx_data_available_n = (rxq.size() == 0);
    tx_space_available_n = tx_stall;
    // Released bus shows a changing pattern
    fifo_data_in = (!fifo_oe_n && rxq.size() > 0) ? rxq[0] : ~fifo_data_in;
  end

  always #1 if (!sync_on) begin
    if (!rec_rd && fifo_rd_n) rx_data_available_n = (rxq.size() == 0);
    if (!rec_wr && fifo_wr_n) tx_space_available_n = tx_stall;
  end

  always @(negedge fifo_rd_n) if (!sync_on) begin
    if (rx_data_available_n) viol++;
    if (fifo_data_oe) viol++;
    #10;
    if (rxq.size() > 0) fifo_data_in = rxq[0];
  end

  always @(posedge fifo_rd_n) if (!sync_on && rxq.size() > 0) begin
    rec_rd = 1'b1;
    void'(rxq.pop_front());
    #5;
    rx_data_available_n = 1'b1;
    fifo_data_in = ~fifo_data_in;
    #50;
    rec_rd = 1'b0;
  end

  always @(negedge fifo_wr_n) if (!sync_on) begin
    if (tx_space_available_n) viol++;
    if (!fifo_data_oe) viol++;
    txq.push_back(fifo_data_out);
    rec_wr = 1'b1;
    #5;
    tx_space_available_n = 1'b1;
  end

  always @(posedge fifo_wr_n) if (!sync_on && rec_wr) begin
    #55;
    rec_wr = 1'b0;
  end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the FIFO port host controller
// Assumes: Device model stands on the far side of the port
// Notes: Async scenarios first, then sync with the link clock running
`timescale 1ns/1ps
module testbench;
  import usb_fifo_host_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sync_mode_req = 1'b1;
  logic nv_async_cfg = 1'b0;
  logic sync_on = 1'b0;
  logic tx_valid = 1'b0;
  byte_t tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic tx_ready, rx_valid, link_clk, rxf_n, txe_n, rd_n, wr_n, oe_n, data_oe;
  byte_t rx_data, bus_in, bus_out, b;
  int n_errors = 0;
  int check_count = 0;

  always #5 clock = ~clock;

  usb_fifo_host dut (.clock(clock), .rst_b(rst_b), .link_clk(link_clk),
    .sync_mode_req(sync_mode_req), .nv_async_cfg(nv_async_cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .rx_data_available_n(rxf_n), .tx_space_available_n(txe_n),
    .fifo_rd_n(rd_n), .fifo_wr_n(wr_n), .fifo_oe_n(oe_n), .fifo_data_in(bus_in),
    .fifo_data_out(bus_out), .fifo_data_oe(data_oe));

  fifo_dev_model dev (.sync_on(sync_on), .fifo_rd_n(rd_n), .fifo_wr_n(wr_n),
    .fifo_oe_n(oe_n), .fifo_data_out(bus_out), .fifo_data_oe(data_oe),
    .link_clk(link_clk), .rx_data_available_n(rxf_n), .tx_space_available_n(txe_n),
    .fifo_data_in(bus_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic get_rx(output byte_t v);
    int i;
    for (i = 0; i < 3000 && rx_valid !== 1'b1; i++) tick(1);
    if (i == 3000) begin
      check(16'h0000, 16'h0001);
      conclude();
    end
    v = rx_data;
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask

  task automatic put_tx(input byte_t v);
    int i;
    tx_data = v;
    tx_valid = 1'b1;
    for (i = 0; i < 3000 && tx_ready !== 1'b1; i++) tick(1);
    if (i == 3000) begin
      check(16'h0000, 16'h0001);
      conclude();
    end
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask

  task automatic check_txq(input byte_t exp[$]);
    check(16'(dev.txq.size()), 16'(exp.size()));
    foreach (exp[i]) check(dev.txq[i], exp[i]);
    dev.txq.delete();
  endtask

  // Async mode never drives output enable
  always @(negedge clock) if (!sync_on && rst_b && oe_n !== 1'b1) check(oe_n, 1'b1);

  task automatic reset_values;
    check({rd_n, wr_n, oe_n}, 3'h7);
    check({data_oe, rx_valid}, 2'h0);
  endtask

  task automatic async_read;
    byte_t exp[$] = '{8'hA5, 8'hFF, 8'h00};
    foreach (exp[i]) dev.rxq.push_back(exp[i]);
    tick(100);
    check(16'(dev.rxq.size()), 16'h0002);
    foreach (exp[i]) begin
      get_rx(b);
      check(b, exp[i]);
    end
    tick(20);
    check(rd_n, 1'b1);
  endtask

  task automatic async_write;
    dev.tx_stall = 1'b1;
    // Let the stalled space flag pass the host synchroniser first
    tick(5);
    fork
      put_tx(8'h3C);
      begin
        tick(60);
        check(16'(dev.txq.size()), 16'h0000);
        dev.tx_stall = 1'b0;
      end
    join
    put_tx(8'h81);
    put_tx(8'hFF);
    tick(40);
    check_txq('{8'h3C, 8'h81, 8'hFF});
  endtask

  task automatic go_sync;
    nv_async_cfg = 1'b1;
    sync_on = 1'b1;
    tick(30);
  endtask

  task automatic sync_read;
    byte_t exp[$] = '{8'h01, 8'h80, 8'h7F, 8'hFE};
    foreach (exp[i]) dev.rxq.push_back(exp[i]);
    tick(30);
    foreach (exp[i]) begin
      get_rx(b);
      check(b, exp[i]);
    end
    tick(30);
    check({oe_n, rd_n}, 2'h3);
  endtask

  task automatic sync_write;
    dev.tx_stall = 1'b1;
    fork
      put_tx(8'hC3);
      begin
        tick(40);
        check(16'(dev.txq.size()), 16'h0000);
        dev.tx_stall = 1'b0;
      end
    join
    put_tx(8'h00);
    put_tx(8'h5F);
    tick(40);
    check_txq('{8'hC3, 8'h00, 8'h5F});
  endtask

  task automatic sync_both;
    byte_t rxe[$] = '{8'h11, 8'h22, 8'h33};
    foreach (rxe[i]) dev.rxq.push_back(rxe[i]);
    fork
      foreach (rxe[i]) put_tx(rxe[i] + 8'h33);
      foreach (rxe[i]) begin
        get_rx(b);
        check(b, rxe[i]);
      end
    join
    tick(40);
    check_txq('{8'h44, 8'h55, 8'h66});
  endtask

  initial begin
    tick(20);
    rst_b = 1'b1;
    tick(5);
    reset_values();
    async_read();
    async_write();
    go_sync();
    sync_read();
    sync_write();
    sync_both();
    check(16'(dev.viol), 16'h0000);
    conclude();
  end
endmodule
